/* File: bench/bsfeu_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module bsfeu_core_tb;
   logic MCLK = 1'b0;
   logic NRST = 1'b0;
   bsfeu_pkg::bsfeu_instr_s INSTR;
   logic [7:0] STACK_RDATA;
   bsfeu_pkg::bsfeu_wb_s WB;
   logic [7:0] STATUS_FLAGS;
   logic DONE;
   logic BUSY;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int tk[$];
   logic [26:0] ex[$];
   logic [26:0] res[$];
   logic [7:0] sq[$];
   logic [7:0] sf = bsfeu_pkg::FLAGS_RST;

   always #12.5 MCLK = ~MCLK;

   bsfeu_core DUT (.MCLK(MCLK), .NRST(NRST), .INSTR(INSTR), .STACK_RDATA(STACK_RDATA),
      .WB(WB), .STATUS_FLAGS(STATUS_FLAGS), .DONE(DONE), .BUSY(BUSY));
   bsfeu_dec_model PM (.clk(MCLK), .rst_n(NRST), .busy(BUSY), .done(DONE), .wb(WB),
      .instr(INSTR), .stack_rdata(STACK_RDATA));

   // ----------------------------------------
   // Completion monitor: strobes, addr, data, flags, latency
   // ----------------------------------------
   always @(posedge MCLK) begin
      cyc = cyc + 1;
      if (NRST && INSTR.valid && !BUSY) begin
         tk.push_back(cyc);
      end
      if (DONE) begin
         res.push_back({WB.reg_we, WB.io_we, WB.push, WB.pop, WB.addr, WB.data,
            STATUS_FLAGS, 2'(cyc - tk.pop_front())});
      end
   end

   function automatic logic [26:0] mask(input logic [26:0] v);
      logic [26:0] m;
      m = v;
      if (v[26:25] == 2'h0) m[22:18] = 5'h00;
      if (v[26:23] == 4'h0) m[17:10] = 8'h00;
      return m;
   endfunction

   task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] g);
      n_compared++;
      if (e !== g) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Queue one op and its expected outcome from the shadow flags and stack
   task automatic issue(input bsfeu_pkg::bsfeu_op_e op, input logic [2:0] b,
      input logic [7:0] d);
      bsfeu_pkg::bsfeu_instr_s i;
      logic [7:0] r;
      logic [3:0] we;
      logic [1:0] lat;
      logic c;
      r = d;
      c = sf[bsfeu_pkg::FLAG_C];
      we = 4'h8;
      lat = 2'h1;
      case (op)
         bsfeu_pkg::IO_BIT_SET_OP: {we, lat, r[b]} = {4'h4, bsfeu_pkg::CYC_LONG, 1'b1};
         bsfeu_pkg::IO_BIT_CLEAR_OP: {we, lat, r[b]} = {4'h4, bsfeu_pkg::CYC_LONG, 1'b0};
         bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP: {c, r} = {d, 1'b0};
         bsfeu_pkg::LOGICAL_RIGHT_SHIFT_OP: {r, c} = {1'b0, d};
         bsfeu_pkg::ROTATE_LEFT_CARRY_OP: {c, r} = {d, c};
         bsfeu_pkg::ROTATE_RIGHT_CARRY_OP: {r, c} = {c, d};
         bsfeu_pkg::ARITH_RIGHT_SHIFT_OP: {r, c} = {d[7], d};
         bsfeu_pkg::NIBBLE_SWAP_OP: r = {d[3:0], d[7:4]};
         bsfeu_pkg::STATUS_BIT_SET_OP: {we, sf[b]} = {4'h0, 1'b1};
         bsfeu_pkg::STATUS_BIT_CLEAR_OP: {we, sf[b]} = {4'h0, 1'b0};
         bsfeu_pkg::REG_BIT_TO_TRANSFER_FLAG_OP: {we, sf[bsfeu_pkg::FLAG_T]} = {4'h0, d[b]};
         bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP: r[b] = sf[bsfeu_pkg::FLAG_T];
         bsfeu_pkg::STACK_PUSH_OP: {we, lat} = {4'h2, bsfeu_pkg::CYC_LONG};
         bsfeu_pkg::STACK_POP_OP: {we, lat, r} = {4'h9, bsfeu_pkg::CYC_LONG, sq.pop_back()};
         default: we = 4'h0;
      endcase
      if (op == bsfeu_pkg::STACK_PUSH_OP) sq.push_back(d);
      if (op inside {[bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP:bsfeu_pkg::ARITH_RIGHT_SHIFT_OP]}) begin
         sf[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      end
      i = '{valid: 1'b1, op: op, bsel: b, addr: d[4:0] ^ 5'h15, operand: d};
      PM.q.push_back(i);
      ex.push_back({we, i.addr, r, sf, lat});
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (res.size() < ex.size() && n < 100) begin
         @(negedge MCLK);
         n++;
      end
      if (res.size() < ex.size()) begin
         errors++;
         $display("BAD completion count expected %0d seen %0d", ex.size(), res.size());
         wrap_up();
      end
      while (ex.size() != 0) chk("wb_flags_latency", mask(ex.pop_front()), mask(res.pop_front()));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_shifts();
      logic [7:0] v[4] = '{8'h81, 8'h00, 8'h80, 8'h01};
      bsfeu_pkg::bsfeu_op_e o;
      o = bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP;
      repeat (5) begin
         foreach (v[k]) issue(o, 3'h0, v[k]);
         o = o.next();
      end
      drain();
   endtask

   task automatic t_bits();
      issue(bsfeu_pkg::NIBBLE_SWAP_OP, 3'h0, 8'hA5);
      issue(bsfeu_pkg::REG_BIT_TO_TRANSFER_FLAG_OP, 3'h7, 8'h80);
      issue(bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP, 3'h0, 8'h00);
      issue(bsfeu_pkg::REG_BIT_TO_TRANSFER_FLAG_OP, 3'h0, 8'h80);
      issue(bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP, 3'h7, 8'hFF);
      drain();
   endtask

   task automatic t_flags();
      for (int f = 0; f < 8; f++) issue(bsfeu_pkg::STATUS_BIT_SET_OP, 3'(f), 8'h00);
      for (int f = 0; f < 8; f++) issue(bsfeu_pkg::STATUS_BIT_CLEAR_OP, 3'(f), 8'h00);
      drain();
   endtask

   task automatic t_io();
      issue(bsfeu_pkg::STATUS_BIT_SET_OP, 3'(bsfeu_pkg::FLAG_H), 8'h00);
      issue(bsfeu_pkg::IO_BIT_SET_OP, 3'h0, 8'h00);
      issue(bsfeu_pkg::IO_BIT_CLEAR_OP, 3'h7, 8'hFF);
      issue(bsfeu_pkg::IO_BIT_SET_OP, 3'h7, 8'h7F);
      issue(bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP, 3'h0, 8'h40);
      drain();
   endtask

   task automatic t_stack();
      issue(bsfeu_pkg::STACK_PUSH_OP, 3'h0, 8'h5A);
      issue(bsfeu_pkg::STACK_PUSH_OP, 3'h0, 8'hC3);
      issue(bsfeu_pkg::STACK_POP_OP, 3'h0, 8'h00);
      issue(bsfeu_pkg::STACK_POP_OP, 3'h0, 8'h00);
      drain();
   endtask

   // Mid-run reset must clear flags set before it
   task automatic t_reset();
      issue(bsfeu_pkg::STATUS_BIT_SET_OP, 3'(bsfeu_pkg::FLAG_I), 8'h00);
      drain();
      @(posedge MCLK);
      NRST <= 1'b0;
      repeat (3) @(posedge MCLK);
      NRST <= 1'b1;
      sf = bsfeu_pkg::FLAGS_RST;
      @(negedge MCLK);
      chk("reset_again", {19'h0, bsfeu_pkg::FLAGS_RST}, {17'h0, DONE, BUSY, STATUS_FLAGS});
      issue(bsfeu_pkg::ROTATE_LEFT_CARRY_OP, 3'h0, 8'h80);
      drain();
   endtask

   initial begin
      repeat (3) @(posedge MCLK);
      NRST <= 1'b1;
      @(negedge MCLK);
      chk("reset_state", {19'h0, bsfeu_pkg::FLAGS_RST}, {17'h0, DONE, BUSY, STATUS_FLAGS});
      t_shifts();
      t_bits();
      t_flags();
      t_io();
      t_stack();
      t_reset();
      wrap_up();
   end
endmodule

`default_nettype wire

/* File: bench/bsfeu_dec_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bsfeu_dec_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Execute unit side
   input wire logic busy,
   input wire logic done,
   input wire bsfeu_pkg::bsfeu_wb_s wb,
   output var bsfeu_pkg::bsfeu_instr_s instr,
   output var logic [7:0] stack_rdata
);
   bsfeu_pkg::bsfeu_instr_s q[$];
   logic [7:0] stk[$];
   logic [7:0] junk;
   logic adv;

   initial begin
      instr = '0;
      junk = 8'h00;
   end

   // A long op is held over its busy cycle, then replaced
   always_comb begin
      adv = !instr.valid || busy || !(instr.op inside {bsfeu_pkg::IO_BIT_SET_OP,
         bsfeu_pkg::IO_BIT_CLEAR_OP, bsfeu_pkg::STACK_PUSH_OP, bsfeu_pkg::STACK_POP_OP});
      // Empty stack shows a changing byte, never a stale one
      stack_rdata = (stk.size() != 0) ? stk[$] : junk;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr <= '0;
      end else begin
         junk <= ~junk;
         if (adv) begin
            instr <= (q.size() != 0) ? q.pop_front() : '0;
         end
         if (done && wb.push) begin
            stk.push_back(wb.data);
         end
         if (done && wb.pop && stk.size() != 0) begin
            void'(stk.pop_back());
         end
      end
   end
endmodule

`default_nettype wire

/* File: core/bsfeu_core.sv */
// Overview of operation
// - I/O bit set writes one to selected bit, flags kept, two cycles.
// - I/O bit clear writes zero to selected bit, flags kept, two cycles.
// - Logical left shift, zero into bit 0, updates Z C N V, one cycle.
// - Logical right shift, zero into bit 7, updates Z C N V, one cycle.
// - Rotate left through carry, old bit 7 to carry, one cycle.
// - Rotate right through carry, old bit 0 to carry, one cycle.
// - Arithmetic right shift keeps sign bit, updates Z C N V, one cycle.
// - Nibble swap exchanges halves, flags unchanged, one cycle.
// - Status bit set writes one to chosen flag only, one cycle.
// - Copy selected register bit into transfer flag only, one cycle.
// - Copy transfer flag into selected register bit, flags kept, one cycle.
// - Named flags C N Z I S individually set or cleared, one cycle.
// - Overflow flag forced to one or zero alone, one cycle.
// - Half-carry flag forced to one or zero alone, one cycle.
// - Push places source register on stack in two cycles, flags kept.
// - Pop loads destination register from stack in two cycles, flags kept.
`timescale 1ns/100ps
`default_nettype none

module bsfeu_core (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // Instruction from decoder, held for two-cycle ops
   input wire bsfeu_pkg::bsfeu_instr_s INSTR,
   // Stack data returned for a pop
   input wire logic [7:0] STACK_RDATA,
   // Write-back and status
   output var bsfeu_pkg::bsfeu_wb_s WB,
   output var logic [7:0] STATUS_FLAGS,
   output var logic DONE,
   output var logic BUSY
);

   bsfeu_pkg::bsfeu_state_s s_reg;
   bsfeu_pkg::bsfeu_state_s s_next;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction

   // Flags after a shift: Z, N, V from result and new carry
   // V uses the new N and C, so callers pass the carry out of the shift
   function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
                                              input logic c);
      logic [7:0] o;
      o = f;
      o[bsfeu_pkg::FLAG_C] = c;
      o[bsfeu_pkg::FLAG_Z] = (r == 8'h00);
      o[bsfeu_pkg::FLAG_N] = r[7];
      o[bsfeu_pkg::FLAG_V] = r[7] ^ c;
      shift_flags = o;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] d;
      logic [7:0] r;
      logic c;
      d = INSTR.operand;
      r = 8'h00;
      c = s_reg.flags[bsfeu_pkg::FLAG_C];
      s_next = s_reg;
      s_next.wb = '0;
      s_next.done = 1'b0;
      unique case (s_reg.state)
         bsfeu_pkg::ST_IDLE: begin
            s_next.busy = 1'b0;
            if (INSTR.valid) begin
               s_next.op = INSTR.op;
               s_next.bsel = INSTR.bsel;
               s_next.operand = INSTR.operand;
               s_next.wb.addr = INSTR.addr;
               unique case (INSTR.op)
                  // Two-cycle ops: the write lands in the second cycle
                  bsfeu_pkg::IO_BIT_SET_OP, bsfeu_pkg::IO_BIT_CLEAR_OP,
                  bsfeu_pkg::STACK_PUSH_OP, bsfeu_pkg::STACK_POP_OP: begin
                     s_next.state = bsfeu_pkg::ST_SECOND;
                     s_next.cyc = 2'h1;
                     s_next.busy = 1'b1;
                  end
                  bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP: begin
                     r = {d[6:0], 1'b0};
                     s_next.flags = shift_flags(s_reg.flags, r, d[7]);
                  end
                  bsfeu_pkg::LOGICAL_RIGHT_SHIFT_OP: begin
                     r = {1'b0, d[7:1]};
                     s_next.flags = shift_flags(s_reg.flags, r, d[0]);
                  end
                  bsfeu_pkg::ROTATE_LEFT_CARRY_OP: begin
                     r = {d[6:0], c};
                     s_next.flags = shift_flags(s_reg.flags, r, d[7]);
                  end
                  bsfeu_pkg::ROTATE_RIGHT_CARRY_OP: begin
                     r = {c, d[7:1]};
                     s_next.flags = shift_flags(s_reg.flags, r, d[0]);
                  end
                  bsfeu_pkg::ARITH_RIGHT_SHIFT_OP: begin
                     r = {d[7], d[7:1]};
                     s_next.flags = shift_flags(s_reg.flags, r, d[0]);
                  end
                  bsfeu_pkg::NIBBLE_SWAP_OP: begin
                     r = {d[3:0], d[7:4]};
                  end
                  bsfeu_pkg::STATUS_BIT_SET_OP: begin
                     // Covers named C N Z I S V H T set forms
                     s_next.flags = s_reg.flags | bit_mask(INSTR.bsel);
                  end
                  bsfeu_pkg::STATUS_BIT_CLEAR_OP: begin
                     s_next.flags = s_reg.flags & ~bit_mask(INSTR.bsel);
                  end
                  bsfeu_pkg::REG_BIT_TO_TRANSFER_FLAG_OP: begin
                     s_next.flags[bsfeu_pkg::FLAG_T] = d[INSTR.bsel];
                  end
                  bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP: begin
                     r = d;
                     r[INSTR.bsel] = s_reg.flags[bsfeu_pkg::FLAG_T];
                  end
                  default: begin
                  end
               endcase
               if (s_next.state == bsfeu_pkg::ST_IDLE) begin
                  s_next.done = 1'b1;
                  s_next.wb.data = r;
                  s_next.wb.reg_we = INSTR.op inside {bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP,
                     bsfeu_pkg::LOGICAL_RIGHT_SHIFT_OP, bsfeu_pkg::ROTATE_LEFT_CARRY_OP,
                     bsfeu_pkg::ROTATE_RIGHT_CARRY_OP, bsfeu_pkg::ARITH_RIGHT_SHIFT_OP,
                     bsfeu_pkg::NIBBLE_SWAP_OP, bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP};
               end
            end
         end
         bsfeu_pkg::ST_SECOND: begin
            // Decoder holds the instruction here; flags are left alone
            s_next.state = bsfeu_pkg::ST_IDLE;
            s_next.cyc = bsfeu_pkg::CYC_LONG;
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.wb.addr = s_reg.wb.addr;
            unique case (s_reg.op)
               bsfeu_pkg::IO_BIT_SET_OP: begin
                  s_next.wb.io_we = 1'b1;
                  s_next.wb.data = s_reg.operand | bit_mask(s_reg.bsel);
               end
               bsfeu_pkg::IO_BIT_CLEAR_OP: begin
                  s_next.wb.io_we = 1'b1;
                  s_next.wb.data = s_reg.operand & ~bit_mask(s_reg.bsel);
               end
               bsfeu_pkg::STACK_PUSH_OP: begin
                  s_next.wb.push = 1'b1;
                  s_next.wb.data = s_reg.operand;
               end
               bsfeu_pkg::STACK_POP_OP: begin
                  // Stack top is taken in this cycle; the pointer moves on the pop strobe
                  s_next.wb.pop = 1'b1;
                  s_next.wb.reg_we = 1'b1;
                  s_next.wb.data = STACK_RDATA;
               end
               default: begin
               end
            endcase
         end
         default: begin
            s_next.state = bsfeu_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         s_reg <= '{state: bsfeu_pkg::ST_IDLE, op: bsfeu_pkg::NOP_OP, cyc: 2'h0,
                    bsel: 3'h0, operand: bsfeu_pkg::DATA_RST, flags: bsfeu_pkg::FLAGS_RST,
                    wb: '0, done: 1'b0, busy: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign WB = s_reg.wb;
   assign STATUS_FLAGS = s_reg.flags;
   assign DONE = s_reg.done;
   assign BUSY = s_reg.busy;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);

   a_io_set_two: assert property (
      BUSY && !DONE && s_reg.op == bsfeu_pkg::IO_BIT_SET_OP |=> WB.io_we && DONE
         && WB.data[s_reg.bsel] && $stable(STATUS_FLAGS))
      else $error("io bit set wrong");
   a_io_clr_two: assert property (
      BUSY && s_reg.op == bsfeu_pkg::IO_BIT_CLEAR_OP |=> WB.io_we && DONE
         && !WB.data[s_reg.bsel] && $stable(STATUS_FLAGS))
      else $error("io bit clear wrong");

   // ----------------------------------------
   // Checks: shifts and nibble swap
   // ----------------------------------------
   a_left_shift: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP |=>
         WB.reg_we && WB.data == {$past(INSTR.operand[6:0]), 1'b0}
         && STATUS_FLAGS[bsfeu_pkg::FLAG_C] == $past(INSTR.operand[7]))
      else $error("left shift wrong");
   a_right_shift: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::LOGICAL_RIGHT_SHIFT_OP |=>
         WB.data == {1'b0, $past(INSTR.operand[7:1])})
      else $error("right shift wrong");
   a_swap_flags: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::NIBBLE_SWAP_OP |=>
         $stable(STATUS_FLAGS) && WB.data == {$past(INSTR.operand[3:0]),
         $past(INSTR.operand[7:4])})
      else $error("swap wrong");
   a_shift_vflag: assert property (
      DONE && WB.reg_we && s_reg.op inside {bsfeu_pkg::LOGICAL_LEFT_SHIFT_OP,
         bsfeu_pkg::ARITH_RIGHT_SHIFT_OP} |-> STATUS_FLAGS[bsfeu_pkg::FLAG_V] ==
         (STATUS_FLAGS[bsfeu_pkg::FLAG_N] ^ STATUS_FLAGS[bsfeu_pkg::FLAG_C])
         && STATUS_FLAGS[bsfeu_pkg::FLAG_Z] == (WB.data == 8'h00))
      else $error("shift flags wrong");

   // ----------------------------------------
   // Checks: status flags and push timing
   // ----------------------------------------
   a_flag_set_one: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::STATUS_BIT_SET_OP |=>
         STATUS_FLAGS == ($past(STATUS_FLAGS) | (8'h01 << $past(INSTR.bsel))))
      else $error("flag set wrong");
   a_flag_clr_one: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::STATUS_BIT_CLEAR_OP |=>
         STATUS_FLAGS == ($past(STATUS_FLAGS) & ~(8'h01 << $past(INSTR.bsel))))
      else $error("flag clear wrong");
   a_push_two: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::STACK_PUSH_OP |=>
         !DONE ##1 WB.push && DONE)
      else $error("push timing wrong");

   // ----------------------------------------
   // Checks: rotates, arithmetic right shift and sign flags
   // ----------------------------------------
   // Rotates read the carry held here, so back-to-back rotates chain
   a_rotate_left: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::ROTATE_LEFT_CARRY_OP |=>
         WB.reg_we && WB.data[7:1] == $past(INSTR.operand[6:0])
         && WB.data[0] == $past(STATUS_FLAGS[bsfeu_pkg::FLAG_C])
         && STATUS_FLAGS[bsfeu_pkg::FLAG_C] == $past(INSTR.operand[7]))
      else $error("rotate left wrong");

   a_rotate_right: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::ROTATE_RIGHT_CARRY_OP |=>
         WB.reg_we && WB.data[6:0] == $past(INSTR.operand[7:1])
         && WB.data[7] == $past(STATUS_FLAGS[bsfeu_pkg::FLAG_C])
         && STATUS_FLAGS[bsfeu_pkg::FLAG_C] == $past(INSTR.operand[0]))
      else $error("rotate right wrong");

   a_arith_right: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::ARITH_RIGHT_SHIFT_OP |=>
         WB.reg_we && WB.data == {$past(INSTR.operand[7]), $past(INSTR.operand[7:1])}
         && STATUS_FLAGS[bsfeu_pkg::FLAG_C] == $past(INSTR.operand[0]))
      else $error("arithmetic shift wrong");

   a_shift_nflag: assert property (
      DONE && WB.reg_we && s_reg.op inside {bsfeu_pkg::LOGICAL_RIGHT_SHIFT_OP,
         bsfeu_pkg::ROTATE_LEFT_CARRY_OP, bsfeu_pkg::ROTATE_RIGHT_CARRY_OP} |->
         STATUS_FLAGS[bsfeu_pkg::FLAG_N] == WB.data[7]
         && STATUS_FLAGS[bsfeu_pkg::FLAG_V] == (WB.data[7] ^ STATUS_FLAGS[bsfeu_pkg::FLAG_C]))
      else $error("shift sign flags wrong");

   // ----------------------------------------
   // Checks: bit transfer and named flag isolation
   // ----------------------------------------
   a_tflag_copy: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::REG_BIT_TO_TRANSFER_FLAG_OP |=>
         STATUS_FLAGS[bsfeu_pkg::FLAG_T]
         == (|($past(INSTR.operand) & bit_mask($past(INSTR.bsel))))
         && (STATUS_FLAGS & ~bit_mask(3'(bsfeu_pkg::FLAG_T)))
         == ($past(STATUS_FLAGS) & ~bit_mask(3'(bsfeu_pkg::FLAG_T))) && !WB.reg_we)
      else $error("transfer flag copy wrong");

   a_tflag_load: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP |=>
         WB.reg_we && $stable(STATUS_FLAGS)
         && (WB.data & ~bit_mask(s_reg.bsel))
         == ($past(INSTR.operand) & ~bit_mask(s_reg.bsel))
         && (|(WB.data & bit_mask(s_reg.bsel))) == STATUS_FLAGS[bsfeu_pkg::FLAG_T])
      else $error("transfer flag load wrong");

   a_named_flag_only: assert property (
      INSTR.valid && !BUSY && INSTR.op inside {bsfeu_pkg::STATUS_BIT_SET_OP,
         bsfeu_pkg::STATUS_BIT_CLEAR_OP} |=> !WB.reg_we && !WB.io_we
         && ((STATUS_FLAGS ^ $past(STATUS_FLAGS)) & ~bit_mask($past(INSTR.bsel))) == 8'h00)
      else $error("named flag op touched another bit");

   // ----------------------------------------
   // Checks: two-cycle operations, write-back strobes and one-cycle done
   // ----------------------------------------
   // The decoder keeps the op on INSTR through the busy cycle too; two edges back is the taking edge
   a_long_count: assert property (
      BUSY |-> (s_reg.state == bsfeu_pkg::ST_SECOND && s_reg.cyc == 2'h1) ##1
         (!BUSY && DONE && s_reg.cyc == bsfeu_pkg::CYC_LONG && $stable(STATUS_FLAGS)))
      else $error("two-cycle count wrong");

   a_pop_two: assert property (
      INSTR.valid && !BUSY && INSTR.op == bsfeu_pkg::STACK_POP_OP |=>
         BUSY && !DONE ##1 DONE && WB.pop && WB.reg_we
         && WB.data == $past(STACK_RDATA) && $stable(STATUS_FLAGS))
      else $error("pop wrong");

   a_push_data: assert property (
      DONE && WB.push |-> WB.data == $past(INSTR.operand, 2) && !WB.reg_we && !WB.io_we)
      else $error("push data wrong");

   a_io_set_data: assert property (
      DONE && WB.io_we && s_reg.op == bsfeu_pkg::IO_BIT_SET_OP |->
         WB.data == ($past(INSTR.operand, 2) | bit_mask(s_reg.bsel)))
      else $error("io bit set changed other bits");

   a_io_clr_data: assert property (
      DONE && WB.io_we && s_reg.op == bsfeu_pkg::IO_BIT_CLEAR_OP |->
         WB.data == ($past(INSTR.operand, 2) & ~bit_mask(s_reg.bsel)))
      else $error("io bit clear changed other bits");

   a_io_addr: assert property (
      DONE && WB.io_we |-> WB.addr == $past(INSTR.addr, 2) && $past(BUSY))
      else $error("io write address wrong");

   a_wb_with_done: assert property (
      (WB.reg_we || WB.io_we || WB.push || WB.pop) |-> DONE)
      else $error("write-back strobe without done");

   a_short_done: assert property (
      INSTR.valid && !BUSY && !(INSTR.op inside {bsfeu_pkg::IO_BIT_SET_OP,
         bsfeu_pkg::IO_BIT_CLEAR_OP, bsfeu_pkg::STACK_PUSH_OP, bsfeu_pkg::STACK_POP_OP})
         |=> DONE && !BUSY)
      else $error("one-cycle op did not finish");

   // Main scenarios reached
   c_io_set: cover property (DONE && WB.io_we);
   c_pop: cover property (DONE && WB.pop);
   c_rotate: cover property (DONE && s_reg.op == bsfeu_pkg::ROTATE_RIGHT_CARRY_OP);
   c_tflag_load: cover property (DONE && s_reg.op == bsfeu_pkg::TRANSFER_FLAG_TO_REG_BIT_OP);
   c_back_to_back: cover property (DONE ##1 DONE);

endmodule

`default_nettype wire

/* File: include/bsfeu_pkg.sv */
package bsfeu_pkg;

   // ----------------------------------------
   // Status flag bit positions
   // ----------------------------------------
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // ----------------------------------------
   // Reset values and cycle counts
   // ----------------------------------------
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [4:0] ADDR_RST = 5'h00;
   localparam logic [1:0] CYC_LONG = 2'h2;

   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      NOP_OP = 4'b0000,
      IO_BIT_SET_OP = 4'b0001,
      IO_BIT_CLEAR_OP = 4'b0010,
      LOGICAL_LEFT_SHIFT_OP = 4'b0011,
      LOGICAL_RIGHT_SHIFT_OP = 4'b0100,
      ROTATE_LEFT_CARRY_OP = 4'b0101,
      ROTATE_RIGHT_CARRY_OP = 4'b0110,
      ARITH_RIGHT_SHIFT_OP = 4'b0111,
      NIBBLE_SWAP_OP = 4'b1000,
      STATUS_BIT_SET_OP = 4'b1001,
      STATUS_BIT_CLEAR_OP = 4'b1010,
      REG_BIT_TO_TRANSFER_FLAG_OP = 4'b1011,
      TRANSFER_FLAG_TO_REG_BIT_OP = 4'b1100,
      STACK_PUSH_OP = 4'b1101,
      STACK_POP_OP = 4'b1110
   } bsfeu_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SECOND = 2'b01
   } bsfeu_state_e;

   // Decoded instruction from the decoder
   typedef struct packed {
      logic valid;
      bsfeu_op_e op;
      logic [2:0] bsel;
      logic [4:0] addr;
      logic [7:0] operand;
   } bsfeu_instr_s;

   // Write-back produced toward register file, I/O or stack
   typedef struct packed {
      logic reg_we;
      logic io_we;
      logic push;
      logic pop;
      logic [4:0] addr;
      logic [7:0] data;
   } bsfeu_wb_s;

   typedef struct packed {
      bsfeu_state_e state;
      bsfeu_op_e op;
      logic [1:0] cyc;
      logic [2:0] bsel;
      logic [7:0] operand;
      logic [7:0] flags;
      bsfeu_wb_s wb;
      logic done;
      logic busy;
   } bsfeu_state_s;

endpackage
